//--- verification/ptrd_ctrl_model.sv
`timescale 1ns/100ps
module ptrd_ctrl_model (input wire logic clock_i, input wire logic [1:0] fmt_i, output logic a_o, b_o);
	logic [1:0] ph = 2'h0; // gray position, counts up when the first line leads
	int unsigned stretch = 1; // 1 = full rate; larger slows every level down
	initial {a_o, b_o} = 2'h0;
	// each level lasts half the shortest cycle, so cycle and width minimums both hold
	task automatic hold();
		repeat (ptrd_pkg::STEP_CYCLE_CYC / 2 * stretch) @(posedge clock_i);
		#1;
	endtask
	task automatic step(input logic neg);
		ph = neg ? ph - 2'h1 : ph + 2'h1;
		{a_o, b_o} = fmt_i == 2'h0 ? {^ph, ph[1]} : {fmt_i == 2'h1 || !neg, neg};
		hold();
		if (fmt_i != 2'h0) {a_o, b_o} = {1'h0, fmt_i == 2'h1 && neg};
		hold();
	endtask
	// lines back to zero, so the next format starts from a clean edge
	task automatic rest();
		{ph, a_o, b_o} = 4'h0;
		hold();
	endtask
endmodule

//--- verification/ptrd_decoder_properties.sv
`timescale 1ns/100ps
module ptrd_decoder_properties (input wire logic clock_i, rst_b_i, egear_active_i,
	quad_phase_first_i, quad_phase_second_i, step_o, step_neg_o, input wire logic [1:0] format_i);
	wire a = quad_phase_first_i, b = quad_phase_second_i, p = step_o & !step_neg_o, n = step_o & step_neg_o;
	wire [1:0] m = egear_active_i ? format_i : 2'h3; // gear off behaves like the dead format
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	gear_gate_a: assert property (m == 2'h3 |=> !step_o) else $error("idle step");
	dir_sample_a: assert property (m == 2'h1 && $rose(a) |=> step_o && step_neg_o == $past(b)) else $error("dir");
	strobe_low_a: assert property (m == 2'h1 && !a |=> !step_o) else $error("no strobe");
	fwd_step_a: assert property (m == 2'h2 && $rose(a) && !$rose(b) |=> p) else $error("fwd");
	rev_step_a: assert property (m == 2'h2 && $rose(b) && !$rose(a) |=> n) else $error("rev");
	quad_up_a: assert property (m == 2'h0 && $rose(a) && !b && $stable(b) |=> p) else $error("up");
	quad_down_a: assert property (m == 2'h0 && $rose(b) && !a && $stable(a) |=> n) else $error("down");
	sign_hold_a: assert property (!step_o |-> $stable(step_neg_o)) else $error("sign moved");
	cover property (p);
	cover property (n);
	cover property (m == 2'h1 && $fell(a));
endmodule
bind ptrd_decoder ptrd_decoder_properties u_props (.*);

//--- verification/tb_pulse_train_reference_decoder.sv
`timescale 1ns/100ps
module tb_pulse_train_reference_decoder;
	logic clock_i = 1'h0, rst_b_i = 1'h0, egear_active_i = 1'h0, a, b, step_o, step_neg_o, neg;
	logic [1:0] format_i = 2'h0;
	logic exp_q[$]; // noted signs, oldest first
	int n_fail = 0, num_checks = 0, seed = 32'h3f6b_bb6f;
	localparam int unsigned SLOW_KHZ = 50; // ceiling for slow wiring on long lines
	always #2.5 clock_i = ~clock_i;
	ptrd_decoder u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .format_i(format_i), .egear_active_i(egear_active_i),
		.quad_phase_first_i(a), .quad_phase_second_i(b), .step_o(step_o), .step_neg_o(step_neg_o));
	ptrd_ctrl_model u_ctl (.clock_i(clock_i), .fmt_i(format_i), .a_o(a), .b_o(b));
	task automatic report_and_stop();
		if (n_fail == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	// sampled on the falling edge, where the one-cycle pulse has settled
	always @(negedge clock_i) if (step_o !== 1'h0) begin
		check_bit("step_o", exp_q.size() > 0, step_o);
		if (exp_q.size() > 0) check_bit("step_neg_o", exp_q.pop_front(), step_neg_o);
	end
	initial begin
		repeat (8) @(posedge clock_i);
		#1 rst_b_i = 1'h1;
		// every format with gear off then on; gear drops before the lines are rested, other changes happen only with the lines at rest
		for (int k = 0; k < 8; k++) begin
			{egear_active_i, format_i} = 3'(k);
			repeat (6) begin
				neg = 1'($random(seed));
				if (k[2] && k[1:0] != 2'h3) exp_q.push_back(neg);
				u_ctl.step(neg);
			end
			egear_active_i = 1'h0;
			u_ctl.rest();
		end
		// slow wiring over a long line: the far end keeps to the lower rate
		u_ctl.stretch = ptrd_pkg::RATE_DIFF_KHZ / SLOW_KHZ;
		{egear_active_i, format_i} = 3'h5;
		repeat (3) begin
			neg = 1'($random(seed));
			exp_q.push_back(neg);
			u_ctl.step(neg);
		end
		egear_active_i = 1'h0;
		u_ctl.rest();
		check_bit("steps_missing", 1'h0, exp_q.size() != 0);
		report_and_stop();
	end
	// the sequence takes about 125 us, including the slow pass
	initial #250us begin
		n_fail++;
		report_and_stop();
	end
endmodule

//--- verilog/ptrd_decoder.sv
`timescale 1ns/100ps
// What this block does
// - three formats: quadrature, step/direction, forward/reverse
// - increments only while electronic gear active
// - first phase leading counts positive
// - second phase leading counts negative
// - one step per strobe rising edge only
// - direction low or open means positive
// - forward line rising edge steps positive
// - reverse line rising edge steps negative
// - resolves up to 1 MHz step rate
module ptrd_decoder (
	input  wire logic       clock_i,          // 200 MHz drive clock
	input  wire logic       rst_b_i,          // async reset, active low
	input  wire logic [1:0] format_i,         // reference format select
	input  wire logic       egear_active_i,   // electronic gear mode on
	input  wire logic       quad_phase_first_i,  // phase a or step strobe or forward
	input  wire logic       quad_phase_second_i, // phase b or direction or reverse
	output logic            step_o,           // one-cycle increment strobe
	output logic            step_neg_o        // sign of increment, 1 = negative
);

	// positions of the two reference lines inside the level and edge vectors
	localparam int unsigned LINE_FIRST  = 0;
	localparam int unsigned LINE_SECOND = 1;
	localparam int unsigned NUM_LINES   = 2;

	// levels seen at the previous edge, one flip-flop per reference line
	logic [1:0]             lines_reg;
	logic [1:0]             lines_next;

	// current levels gathered into one vector, first line in bit 0
	logic [1:0]             lines_now;

	// per-line edge flags against the previous edge
	logic [1:0]             rise_line;
	logic [1:0]             fall_line;
	logic [1:0]             edge_line;

	// format code seen as the enumerated type
	ptrd_pkg::ptrd_fmt_type fmt_sel;

	// candidate increment from the quadrature decoder
	logic                   quad_step;
	logic                   quad_neg;

	// candidate increment from the step and direction decoder
	logic                   stepdir_step;
	logic                   stepdir_neg;

	// candidate increment from the forward and reverse decoder
	logic                   fwdrev_step;
	logic                   fwdrev_neg;

	// registered output strobe and sign
	logic                   step_reg;
	logic                   step_next;
	logic                   neg_reg;
	logic                   neg_next;

	// rising edge of one line between the previous and the current level
	function automatic logic line_rise(
		input logic now_lvl,
		input logic prev_lvl
	);
		line_rise = now_lvl & ~prev_lvl;
	endfunction

	// falling edge of one line between the previous and the current level
	function automatic logic line_fall(
		input logic now_lvl,
		input logic prev_lvl
	);
		line_fall = ~now_lvl & prev_lvl;
	endfunction

	// quadrature sign: after an edge on the first phase, equal levels mean the
	// second phase was leading; after an edge on the second phase the reverse
	function automatic logic quad_sign(
		input logic first_moved,
		input logic first_lvl,
		input logic second_lvl
	);
		if (first_moved) begin
			quad_sign = first_lvl ~^ second_lvl;
		end else begin
			quad_sign = first_lvl ^ second_lvl;
		end
	endfunction

	// the pins are taken as synchronous, so one stage is enough to find edges
	assign lines_now = {quad_phase_second_i, quad_phase_first_i};

	// next value of the previous-level store is simply the current level
	always_comb begin
		lines_next = lines_now;
	end

	// reset level is low, the idle level of an unconnected line, so release
	// gives no false edge while the lines rest
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lines_reg <= ptrd_pkg::LINES_RESET;
		end else begin
			lines_reg <= lines_next;
		end
	end

	// one edge detector per line
	for (genvar gi = 0; gi < NUM_LINES; gi++) begin : g_line
		assign rise_line[gi] = line_rise(lines_now[gi], lines_reg[gi]);
		assign fall_line[gi] = line_fall(lines_now[gi], lines_reg[gi]);
		assign edge_line[gi] = rise_line[gi] | fall_line[gi];
	end

	// format select; code 3 is not a format and falls to the default branch
	assign fmt_sel = ptrd_pkg::ptrd_fmt_type'(format_i);

	// x4 quadrature: an edge on exactly one phase counts one increment;
	// both phases moving together means a lost position and is dropped
	always_comb begin
		quad_step = 1'h0;
		quad_neg  = 1'h0;
		if (edge_line[LINE_FIRST] && !edge_line[LINE_SECOND]) begin
			quad_step = 1'h1;
			quad_neg  = quad_sign(1'h1, lines_now[LINE_FIRST], lines_now[LINE_SECOND]);
		end else if (edge_line[LINE_SECOND] && !edge_line[LINE_FIRST]) begin
			quad_step = 1'h1;
			quad_neg  = quad_sign(1'h0, lines_now[LINE_FIRST], lines_now[LINE_SECOND]);
		end
	end

	// step and direction: only the strobe's rising edge counts, falling is ignored
	always_comb begin
		stepdir_step = rise_line[LINE_FIRST];
		// direction taken in the strobe's own cycle, since its lead time may be zero
		stepdir_neg  = lines_now[LINE_SECOND];
	end

	// forward and reverse: edges on both lines in one cycle cancel each other,
	// because the far end need keep no separation between them
	always_comb begin
		fwdrev_step = rise_line[LINE_FIRST] ^ rise_line[LINE_SECOND];
		fwdrev_neg  = rise_line[LINE_SECOND];
	end

	// pick the active decoder; the sign holds until the next increment
	always_comb begin
		step_next = ptrd_pkg::STEP_RESET;
		neg_next  = neg_reg;
		if (egear_active_i) begin
			unique case (fmt_sel)
				ptrd_pkg::PTRD_FMT_QUAD: begin
					step_next = quad_step;
					if (quad_step) begin
						neg_next = quad_neg;
					end
				end
				ptrd_pkg::PTRD_FMT_STEPDIR: begin
					step_next = stepdir_step;
					if (stepdir_step) begin
						neg_next = stepdir_neg;
					end
				end
				ptrd_pkg::PTRD_FMT_FWDREV: begin
					step_next = fwdrev_step;
					if (fwdrev_step) begin
						neg_next = fwdrev_neg;
					end
				end
				default: begin
					step_next = ptrd_pkg::STEP_RESET; // illegal format code counts nothing
				end
			endcase
		end
	end

	// a 5 ns clock sees 200 cycles per step at 1 MHz, so every step is resolved;
	// back-to-back edges are still decoded one per cycle
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			step_reg <= ptrd_pkg::STEP_RESET;
			neg_reg  <= ptrd_pkg::SIGN_RESET;
		end else begin
			step_reg <= step_next;
			neg_reg  <= neg_next;
		end
	end

	// outputs come straight from the flip-flops
	assign step_o     = step_reg;
	assign step_neg_o = neg_reg;

	// the increment is one clock wide; whoever accumulates it must sample
	// every cycle, there is no buffering of increments in this block

	// limitation: no filtering of glitches is done here, a spike shorter than
	// one clock on a line can still count as an edge if it is sampled

	// trade-off: the quadrature decoder throws away a double edge instead of
	// guessing its sign, which loses a position but never reverses one

endmodule

//--- verilog/ptrd_pkg.sv
package ptrd_pkg;

	// selectable reference formats
	typedef enum logic [1:0] {
		PTRD_FMT_QUAD    = 2'b00,
		PTRD_FMT_STEPDIR = 2'b01,
		PTRD_FMT_FWDREV  = 2'b10
	} ptrd_fmt_type;

	localparam int unsigned CLOCK_MHZ         = 200;
	localparam int unsigned CLOCK_PERIOD_NS   = 5;
	// fastest step rates per wiring, in kHz
	localparam int unsigned RATE_DIFF_KHZ     = 1000;
	localparam int unsigned RATE_PUSHPULL_KHZ = 200;
	localparam int unsigned RATE_OPENCOL_KHZ  = 10;
	// smallest step cycle and pulse width the far end keeps, in ns
	localparam int unsigned STEP_CYCLE_NS     = 1000;
	localparam int unsigned STEP_PULSE_NS     = 400;
	// cycles per minimum pulse and per minimum step cycle, rounded up
	localparam int unsigned STEP_PULSE_CYC    = (STEP_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned STEP_CYCLE_CYC    = (STEP_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// reset values
	localparam logic [1:0] LINES_RESET = 2'h0;
	localparam logic       STEP_RESET  = 1'h0;
	localparam logic       SIGN_RESET  = 1'h0;

endpackage
